// *** design/sgsl_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
//          for the serial gateway status LED.
// Assumes: 10 MHz system clock, 8-bit register port, 4-bit address.
// Notes:   Definitions only; include by bare name.
`ifndef SGSL_PARAMS_SVH
`define SGSL_PARAMS_SVH

// ****************************************************************
// Register offsets on the register port
// ****************************************************************
`define SGSL_CTRL_OFS 4'h0
`define SGSL_SCRLED_OFS 4'h1
`define SGSL_STATUS_OFS 4'h2
`define SGSL_STATE_OFS 4'h3

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SGSL_MODE_LSB 0
`define SGSL_MODE_MSB 1
`define SGSL_RUNLED_BIT 0
`define SGSL_ERRLED_BIT 1
`define SGSL_MODE_RST 2'h0
`define SGSL_LED_RST 1'h0

// ****************************************************************
// Timing: clock rate, millisecond tick, pattern phases in ms
// ****************************************************************
`define SGSL_CLK_PERIOD_NS 100
`define SGSL_MS_NS 1000000
`define SGSL_MS_CYCLES (`SGSL_MS_NS / `SGSL_CLK_PERIOD_NS)
`define SGSL_MS_W 10
`define SGSL_B5_ON_MS 10'h064
`define SGSL_B5_OFF_MS 10'h064
`define SGSL_B1_ON_MS 10'h1f4
`define SGSL_B1_OFF_MS 10'h1f4
`define SGSL_FL_ON_MS 10'h0c8
`define SGSL_FL_OFF_MS 10'h3e8
`define SGSL_OK_SHOW_MS 10'h1f4

`endif

// *** design/sgsl_phase_timer.sv ***
// Purpose: Lit/dark phase timer for one blink or flash pattern.
// Assumes: msTick is a one-cycle pulse once per millisecond.
// Notes:   restart forces the lit phase from count zero.
`timescale 1ns/1ps

module sgsl_phase_timer #(
  parameter int CW = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Timing control
  input wire logic msTick,
  input wire logic restart,
  input wire logic [CW-1:0] onMs,
  input wire logic [CW-1:0] offMs,
  // Phase state
  output logic phaseLit,
  output logic [CW-1:0] phaseCnt
);

  logic lit_q;
  logic lit_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Length of the phase now running and its last tick
  wire logic [CW-1:0] phaseLen = lit_q ? onMs : offMs;
  wire logic phaseEnd = msTick && (cnt_q == phaseLen - CW'(1));

  // Restart beats the phase end so a new pattern opens lit
  always_comb begin
    lit_d = lit_q;
    cnt_d = cnt_q;
    if (restart) begin
      lit_d = 1'h1;
      cnt_d = '0;
    end else if (phaseEnd) begin
      lit_d = !lit_q;
      cnt_d = '0;
    end else if (msTick) begin
      cnt_d = cnt_q + CW'(1);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lit_q <= 1'h1;
      cnt_q <= '0;
    end else begin
      lit_q <= lit_d;
      cnt_q <= cnt_d;
    end
  end

  assign phaseLit = lit_q;
  assign phaseCnt = cnt_q;

endmodule : sgsl_phase_timer

// *** design/sgsl_pkg.sv ***
// Purpose: Types shared by the status LED design.
// Assumes: Nothing beyond the constants header.
// Notes:   Script states are one-hot.
package sgsl_pkg;

  // ****************************************************************
  // Protocol mode held in the control register
  // ****************************************************************
  typedef enum logic [1:0] {
    SGSL_MODE_MB = 2'h0,
    SGSL_MODE_ASC = 2'h1,
    SGSL_MODE_SCR = 2'h2
  } sgsl_mode_t;

  // ****************************************************************
  // Displayed pattern
  // ****************************************************************
  typedef enum logic [2:0] {
    SGSL_PAT_OFF = 3'h0,
    SGSL_PAT_GRN = 3'h1,
    SGSL_PAT_RED = 3'h2,
    SGSL_PAT_GRN5 = 3'h3,
    SGSL_PAT_RED5 = 3'h4,
    SGSL_PAT_RED1 = 3'h5,
    SGSL_PAT_FLASH = 3'h6
  } sgsl_pat_t;

  // ****************************************************************
  // Script startup sequence states
  // ****************************************************************
  typedef enum logic [4:0] {
    SGSL_ST_BOOT = 5'h01,
    SGSL_ST_LOAD = 5'h02,
    SGSL_ST_SHOW = 5'h04,
    SGSL_ST_WAIT = 5'h08,
    SGSL_ST_RUN = 5'h10
  } sgsl_state_t;

endpackage : sgsl_pkg

// *** design/sgsl_status_led.sv ***
// Purpose: Duo status LED driver for the serial protocol gateway.
// Assumes: Status flags synchronous to clock; event flags one cycle.
// Notes:   LED outputs are registered, one cycle behind status flags, two behind event flags.
`timescale 1ns/1ps
`include "sgsl_params.svh"

module sgsl_status_led #(
  parameter int MS_CYCLES = `SGSL_MS_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  // Shared protocol status
  input wire logic initBusy,
  input wire logic cfgValid,
  // Modbus RTU status
  input wire logic mbMaster,
  input wire logic mbExcResp,
  input wire logic mbRxErr,
  input wire logic mbTimeout,
  input wire logic mbBadFunc,
  input wire logic mbBadAddr,
  input wire logic mbAppErr,
  input wire logic mbSeqOk,
  // ASCII status
  input wire logic ascTraffic,
  input wire logic ascReady,
  input wire logic ascStop,
  // Script firmware status
  input wire logic scrSearch,
  input wire logic scrLoadOk,
  input wire logic scrStart,
  input wire logic scrNoScript,
  input wire logic scrError,
  input wire logic scrHalted,
  // Duo LED
  output logic ledRed,
  output logic ledGreen
);

  localparam int MSW = $clog2(MS_CYCLES);
  localparam int TW = `SGSL_MS_W;

  // ****************************************************************
  // State
  // ****************************************************************
  logic [1:0] mode_q;
  logic runLed_q;
  logic errLed_q;
  logic err_q, err_d;
  sgsl_pkg::sgsl_state_t st_q, st_d;
  logic [TW-1:0] okCnt_q, okCnt_d;
  sgsl_pkg::sgsl_pat_t pat, pat_q;
  logic [MSW-1:0] msCnt_q, msCnt_d;
  logic ledRed_q, ledRed_d;
  logic ledGreen_q, ledGreen_d;
  logic msTick;
  logic own_q;
  logic [7:0] rdData_q, rdData_d;
  logic phaseLit;
  logic [TW-1:0] phaseCnt;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  wire logic wrCtrl = regWr && (regAddr == `SGSL_CTRL_OFS);
  wire logic wrScr = regWr && (regAddr == `SGSL_SCRLED_OFS);
  wire logic isMb = mode_q == sgsl_pkg::SGSL_MODE_MB;
  wire logic isAsc = mode_q == sgsl_pkg::SGSL_MODE_ASC;
  wire logic isScr = mode_q == sgsl_pkg::SGSL_MODE_SCR;

  // ****************************************************************
  // Modbus error capture
  // ****************************************************************
  // Master and slave see different error sources
  wire logic mbMasterErr = mbMaster
                           && (mbExcResp || mbRxErr || mbTimeout);
  wire logic mbSlaveErr = !mbMaster && (mbBadFunc || mbBadAddr
                           || mbRxErr || mbAppErr);
  wire logic mbErrEvt = isMb && (mbMasterErr || mbSlaveErr);
  // A new error in the clearing cycle wins, so none is lost
  assign err_d = mbErrEvt ? 1'h1 : (mbSeqOk ? 1'h0 : err_q);

  // ****************************************************************
  // Script startup sequence
  // ****************************************************************
  wire logic okDone = msTick && (okCnt_q == `SGSL_OK_SHOW_MS - TW'(1));
  wire logic scrRun = isScr && (st_q == sgsl_pkg::SGSL_ST_RUN);
  wire logic scrHalt = scrError || scrHalted;
  wire logic scriptOwn = scrRun && !scrHalt;

  // A fresh download always restarts the sequence from the search
  always_comb begin
    st_d = st_q;
    if (scrSearch) begin
      st_d = sgsl_pkg::SGSL_ST_LOAD;
    end else begin
      case (st_q)
        sgsl_pkg::SGSL_ST_BOOT: st_d = st_q;
        sgsl_pkg::SGSL_ST_LOAD: begin
          if (scrLoadOk) begin
            st_d = sgsl_pkg::SGSL_ST_SHOW;
          end else if (scrNoScript) begin
            st_d = sgsl_pkg::SGSL_ST_BOOT;
          end
        end
        sgsl_pkg::SGSL_ST_SHOW: begin
          if (okDone) begin
            st_d = sgsl_pkg::SGSL_ST_WAIT;
          end
        end
        sgsl_pkg::SGSL_ST_WAIT: begin
          if (scrStart) begin
            st_d = sgsl_pkg::SGSL_ST_RUN;
          end
        end
        sgsl_pkg::SGSL_ST_RUN: st_d = st_q;
        default: st_d = sgsl_pkg::SGSL_ST_BOOT;
      endcase
    end
  end

  // Green show time counts whole milliseconds inside SHOW only
  assign okCnt_d = (st_q != sgsl_pkg::SGSL_ST_SHOW || okDone) ? '0
                   : (msTick ? okCnt_q + TW'(1) : okCnt_q);

  // ****************************************************************
  // Pattern selection per mode
  // ****************************************************************
  wire sgsl_pkg::sgsl_pat_t mbPat =
    (initBusy || !cfgValid) ? sgsl_pkg::SGSL_PAT_OFF
    : err_q ? sgsl_pkg::SGSL_PAT_RED
    : sgsl_pkg::SGSL_PAT_GRN;
  wire sgsl_pkg::sgsl_pat_t ascPat =
    initBusy ? sgsl_pkg::SGSL_PAT_OFF
    : !cfgValid ? sgsl_pkg::SGSL_PAT_RED1
    : ascStop ? sgsl_pkg::SGSL_PAT_RED5
    : ascTraffic ? sgsl_pkg::SGSL_PAT_GRN5
    : ascReady ? sgsl_pkg::SGSL_PAT_GRN
    : sgsl_pkg::SGSL_PAT_OFF;
  wire sgsl_pkg::sgsl_pat_t scrPat =
    (st_q == sgsl_pkg::SGSL_ST_LOAD) ? sgsl_pkg::SGSL_PAT_RED
    : (st_q == sgsl_pkg::SGSL_ST_SHOW) ? sgsl_pkg::SGSL_PAT_GRN
    : (st_q == sgsl_pkg::SGSL_ST_BOOT && scrNoScript)
      ? sgsl_pkg::SGSL_PAT_FLASH
    : (st_q == sgsl_pkg::SGSL_ST_RUN && scrHalt)
      ? sgsl_pkg::SGSL_PAT_FLASH
    : sgsl_pkg::SGSL_PAT_OFF;
  assign pat = isMb ? mbPat : isAsc ? ascPat
               : isScr ? scrPat : sgsl_pkg::SGSL_PAT_OFF;

  // Phase lengths; steady patterns ignore them
  wire logic [TW-1:0] onMs =
    (pat == sgsl_pkg::SGSL_PAT_RED1) ? `SGSL_B1_ON_MS
    : (pat == sgsl_pkg::SGSL_PAT_FLASH) ? `SGSL_FL_ON_MS
    : `SGSL_B5_ON_MS;
  wire logic [TW-1:0] offMs =
    (pat == sgsl_pkg::SGSL_PAT_RED1) ? `SGSL_B1_OFF_MS
    : (pat == sgsl_pkg::SGSL_PAT_FLASH) ? `SGSL_FL_OFF_MS
    : `SGSL_B5_OFF_MS;

  // ****************************************************************
  // Millisecond prescaler and phase timer
  // ****************************************************************
  // Restarting the prescaler too keeps the first phase full length
  wire logic restart = pat != pat_q;
  assign msTick = msCnt_q == MSW'(MS_CYCLES - 1);
  assign msCnt_d = (restart || msTick) ? '0 : msCnt_q + MSW'(1);

  sgsl_phase_timer #(
    .CW(TW)
  ) u_sgsl_phase_timer (
    .clock(clock),
    .arst_n(arst_n),
    .msTick(msTick),
    .restart(restart),
    .onMs(onMs),
    .offMs(offMs),
    .phaseLit(phaseLit),
    .phaseCnt(phaseCnt)
  );

  // ****************************************************************
  // LED drive
  // ****************************************************************
  // On a restart the old phase is stale; the new one opens lit
  wire logic litNow = restart || phaseLit;
  wire logic redBlink = (pat == sgsl_pkg::SGSL_PAT_RED5)
                        || (pat == sgsl_pkg::SGSL_PAT_RED1)
                        || (pat == sgsl_pkg::SGSL_PAT_FLASH);
  // One colour per pattern outside script control
  assign ledRed_d = scriptOwn ? errLed_q
                    : (pat == sgsl_pkg::SGSL_PAT_RED)
                      || (redBlink && litNow);
  // Halted script: green frozen at the script's last request
  assign ledGreen_d = scrRun ? runLed_q
                      : (pat == sgsl_pkg::SGSL_PAT_GRN)
                        || (pat == sgsl_pkg::SGSL_PAT_GRN5
                            && litNow);

  // ****************************************************************
  // Read data: valid only in the cycle after the read strobe
  // ****************************************************************
  wire logic [7:0] statusWord = {own_q, pat_q, phaseLit, err_q,
                                 ledGreen_q, ledRed_q};
  wire logic [7:0] rdMux =
    (regAddr == `SGSL_CTRL_OFS) ? {6'h00, mode_q}
    : (regAddr == `SGSL_SCRLED_OFS) ? {6'h00, errLed_q, runLed_q}
    : (regAddr == `SGSL_STATUS_OFS) ? statusWord
    : (regAddr == `SGSL_STATE_OFS) ? {3'h0, st_q}
    : 8'h00;
  assign rdData_d = regRd ? rdMux : 8'h00;

  // ****************************************************************
  // Flip-flops
  // ****************************************************************
  // Software-written control
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= `SGSL_MODE_RST;
      runLed_q <= `SGSL_LED_RST;
      errLed_q <= `SGSL_LED_RST;
    end else begin
      if (wrCtrl) begin
        mode_q <= regWrData[`SGSL_MODE_MSB:`SGSL_MODE_LSB];
      end
      if (wrScr) begin
        runLed_q <= regWrData[`SGSL_RUNLED_BIT];
        errLed_q <= regWrData[`SGSL_ERRLED_BIT];
      end
    end
  end

  // Protocol state, timers and pattern history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_q <= 1'h0;
      st_q <= sgsl_pkg::SGSL_ST_BOOT;
      okCnt_q <= '0;
      pat_q <= sgsl_pkg::SGSL_PAT_OFF;
      msCnt_q <= '0;
    end else begin
      err_q <= err_d;
      st_q <= st_d;
      okCnt_q <= okCnt_d;
      pat_q <= pat;
      msCnt_q <= msCnt_d;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ledRed_q <= 1'h0;
      ledGreen_q <= 1'h0;
      own_q <= 1'h0;
      rdData_q <= 8'h00;
    end else begin
      ledRed_q <= ledRed_d;
      ledGreen_q <= ledGreen_d;
      own_q <= scrRun;
      rdData_q <= rdData_d;
    end
  end

  assign ledRed = ledRed_q;
  assign ledGreen = ledGreen_q;
  assign regRdData = rdData_q;

  // ****************************************************************
  // Assertions and covers
  // ****************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  mb_green_a: assert property (
    isMb && !initBusy && cfgValid && !err_q && !mbErrEvt
    |=> ledGreen && !ledRed ##1 err_q || ledGreen)
    else $error("modbus ready state not steady green");
  master_err_a: assert property (
    isMb && mbMaster && (mbExcResp || mbRxErr || mbTimeout)
    |=> err_q ##1 (ledRed || initBusy || !cfgValid || !isMb))
    else $error("master error did not set red");
  slave_err_a: assert property (
    isMb && !mbMaster && (mbBadFunc || mbBadAddr || mbAppErr)
    |=> err_q)
    else $error("slave error did not set red");
  err_hold_a: assert property (
    err_q && !mbSeqOk |=> err_q)
    else $error("error indication dropped without clean sequence");
  err_clear_a: assert property (
    err_q && mbSeqOk && !mbErrEvt |=> !err_q)
    else $error("clean sequence did not clear error");
  mb_dark_a: assert property (
    isMb && (initBusy || !cfgValid) |=> !ledRed && !ledGreen)
    else $error("modbus init or bad config not dark");
  asc_dark_a: assert property (
    isAsc && initBusy |=> !ledRed && !ledGreen)
    else $error("ascii init not dark");
  blink_five_a: assert property (
    pat == sgsl_pkg::SGSL_PAT_RED5 && !restart && msTick
    && phaseLit && phaseCnt == 10'h063 |=> !phaseLit)
    else $error("5 Hz lit phase not 100 ms");
  blink_one_a: assert property (
    pat == sgsl_pkg::SGSL_PAT_RED1 && !restart && msTick
    && !phaseLit && phaseCnt == 10'h1f3 |=> phaseLit)
    else $error("1 Hz dark phase not 500 ms");
  flash_off_a: assert property (
    pat == sgsl_pkg::SGSL_PAT_FLASH && !restart && msTick
    && !phaseLit && phaseCnt == 10'h3e7 |=> phaseLit)
    else $error("flash dark phase not 1000 ms");
  load_red_a: assert property (
    isScr && st_q == sgsl_pkg::SGSL_ST_LOAD |=> ledRed && !ledGreen)
    else $error("script load not steady red");
  ok_show_a: assert property (
    st_q == sgsl_pkg::SGSL_ST_SHOW && !scrSearch && msTick
    && okCnt_q == 10'h1f3 |=> st_q == sgsl_pkg::SGSL_ST_WAIT)
    else $error("green show did not end after 500 ms");
  script_own_a: assert property (
    scriptOwn |=> ledRed == $past(errLed_q)
    && ledGreen == $past(runLed_q))
    else $error("running script does not own the LED");
  halt_green_a: assert property (
    scrRun && scrHalted |=> ledGreen == $past(runLed_q))
    else $error("green changed while script halted");
  one_colour_a: assert property (
    !own_q |-> !(ledRed && ledGreen))
    else $error("red and green lit together");

  err_cycle_c: cover property (err_q ##[1:50] !err_q);
  script_run_c: cover property (st_q == sgsl_pkg::SGSL_ST_RUN);
  blink_one_c: cover property (
    pat == sgsl_pkg::SGSL_PAT_RED1 && $fell(phaseLit));
  flash_halt_c: cover property (scrRun && scrHalted && ledRed);

endmodule : sgsl_status_led

// *** test/sgsl_led_observer.sv ***
// Purpose: Operator's eye on the duo LED; times every steady span.
// Assumes: One system clock; LED outputs are registered levels.
// Notes:   spanDone pulses one cycle when the colour pair changes.
`timescale 1ns/1ps

module sgsl_led_observer (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Duo LED as the operator sees it
  input wire logic ledRed,
  input wire logic ledGreen,
  // Last finished span: colour pair and length in cycles
  output logic [1:0] spanLvl,
  output int spanLen,
  output logic spanDone
);
  logic [1:0] lvl_q;
  int cnt_q;

  // A change of the pair closes the span; the eye keeps no history
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 2'h0;
      cnt_q <= 0;
      spanLvl <= 2'h0;
      spanLen <= 0;
      spanDone <= 1'b0;
    end else begin
      spanDone <= ({ledRed, ledGreen} != lvl_q);
      if ({ledRed, ledGreen} != lvl_q) begin
        spanLvl <= lvl_q;
        spanLen <= cnt_q;
        cnt_q <= 1;
      end else begin
        cnt_q <= cnt_q + 1;
      end
      lvl_q <= {ledRed, ledGreen};
    end
  end
endmodule : sgsl_led_observer

// *** test/tb_serial_gateway_status_led.sv ***
// Purpose: Self-checking bench for the duo status LED driver.
// Assumes: MS_CYCLES of 10, so 100 ms is 1000 clock cycles.
// Notes:   Spans allow one cycle of slack, the phase restart edge.
`timescale 1ns/1ps
`include "sgsl_params.svh"

module tb_serial_gateway_status_led;
  localparam int MS = 10;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic initBusy = 1'b1;
  logic cfgValid = 1'b0;
  logic mbMaster = 1'b0;
  logic [5:0] mbErr = 6'h00;
  logic mbSeqOk = 1'b0;
  logic ascTraffic = 1'b0;
  logic ascReady = 1'b0;
  logic ascStop = 1'b0;
  logic scrSearch = 1'b0;
  logic scrLoadOk = 1'b0;
  logic scrStart = 1'b0;
  logic scrNoScript = 1'b0;
  logic scrError = 1'b0;
  logic scrHalted = 1'b0;
  logic ledRed;
  logic ledGreen;
  logic [1:0] spanLvl;
  int spanLen;
  logic spanDone;
  int n_fail = 0;
  int comparisons = 0;
  logic [31:0] seed = 32'h35;
  logic scrMode = 1'b0;
  logic rdLate = 1'b0;
  logic ledProbe = 1'b0;
  logic spnProbe = 1'b0;
  logic [7:0] rdQ[$];
  logic [1:0] ledQ[$];
  int spnQ[$];

  // ****************************************************************
  // Design, observer and clock
  // ****************************************************************
  sgsl_status_led #(.MS_CYCLES(MS)) u_sgsl_status_led (
    .clock(clock), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .initBusy(initBusy), .cfgValid(cfgValid),
    .mbMaster(mbMaster), .mbExcResp(mbErr[0]), .mbTimeout(mbErr[1]),
    .mbRxErr(mbErr[2]), .mbBadFunc(mbErr[3]), .mbBadAddr(mbErr[4]),
    .mbAppErr(mbErr[5]), .mbSeqOk(mbSeqOk), .ascTraffic(ascTraffic),
    .ascReady(ascReady), .ascStop(ascStop), .scrSearch(scrSearch),
    .scrLoadOk(scrLoadOk), .scrStart(scrStart),
    .scrNoScript(scrNoScript), .scrError(scrError), .scrHalted(scrHalted),
    .ledRed(ledRed), .ledGreen(ledGreen));
  sgsl_led_observer u_sgsl_led_observer (
    .clock(clock), .arst_n(arst_n), .ledRed(ledRed),
    .ledGreen(ledGreen), .spanLvl(spanLvl), .spanLen(spanLen),
    .spanDone(spanDone));
  always #50 clock = ~clock;

  // ****************************************************************
  // Drivers; each starts and ends just after a rising edge
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask : hold
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
  endtask : rd
  task automatic led(input logic r, input logic g);
    ledQ.push_back({r, g});
    ledProbe <= 1'b1;
    @(posedge clock);
    ledProbe <= 1'b0;
    @(posedge clock);
  endtask : led
  // Waits for a finished span of pair l, passing over skip of them
  task automatic span(input logic [1:0] l, input int n, input int skip);
    int t;
    t = 0;
    while (skip >= 0 && t < 40000) begin
      @(posedge clock);
      t++;
      if (spanDone === 1'b1 && spanLvl === l) skip--;
    end
    spnQ.push_back(t < 40000 ? n : -9);
    spnProbe <= 1'b1;
    @(posedge clock);
    spnProbe <= 1'b0;
    @(posedge clock);
  endtask : span

  // ****************************************************************
  // Monitor: oldest note against the result that appears
  // ****************************************************************
  task automatic cmpRd(input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH regRdData expected %h seen %h", e, s);
    end
  endtask : cmpRd
  task automatic cmpLed(input logic [1:0] e, input logic [1:0] s);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH ledRed,ledGreen expected %b seen %b", e, s);
    end
  endtask : cmpLed
  task automatic cmpSpan(input int e, input int s);
    comparisons++;
    if (s < e - 1 || s > e + 1) begin
      n_fail++;
      $display("MISMATCH spanLen expected %0d seen %0d", e, s);
    end
  endtask : cmpSpan
  // Red and green together only under script control
  always @(posedge clock) begin
    rdLate <= regRd;
    if (rdLate) cmpRd(rdQ.pop_front(), regRdData);
    if (ledProbe) cmpLed(ledQ.pop_front(), {ledRed, ledGreen});
    if (spnProbe) cmpSpan(spnQ.pop_front(), spanLen);
    if (arst_n && !scrMode) cmpLed(2'h0, {ledRed & ledGreen, 1'b0});
  end

  task automatic give_verdict();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog, about twice the expected run of 50000 cycles
  initial begin
    #(90000 * 100);
    n_fail++;
    give_verdict();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rd(`SGSL_CTRL_OFS, 8'h00);
    rd(`SGSL_SCRLED_OFS, 8'h00);
    wr(`SGSL_STATE_OFS, 8'h04);
    rd(`SGSL_STATE_OFS, 8'h01);
    rd(4'h9, 8'h00);
    led(1'b0, 1'b0);
    initBusy <= 1'b0;
    hold(3);
    led(1'b0, 1'b0);
    cfgValid <= 1'b1;
    hold(3);
    led(1'b0, 1'b1);
    // Master errors on bits 0 to 2, slave errors on 3 to 5
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      mbMaster <= (i < 3);
      mbErr[i] <= 1'b1;
      @(posedge clock);
      mbErr[i] <= 1'b0;
      hold(2 + int'(seed[3:0]));
      led(1'b1, 1'b0);
      mbSeqOk <= 1'b1;
      @(posedge clock);
      mbSeqOk <= 1'b0;
      hold(3);
      led(1'b0, 1'b1);
    end
    mbErr[2] <= 1'b1;
    mbSeqOk <= 1'b1;
    @(posedge clock);
    mbErr[2] <= 1'b0;
    mbSeqOk <= 1'b0;
    hold(3);
    led(1'b1, 1'b0);
    // ASCII mode
    wr(`SGSL_CTRL_OFS, 8'h01);
    rd(`SGSL_CTRL_OFS, 8'h01);
    initBusy <= 1'b1;
    hold(3);
    led(1'b0, 1'b0);
    initBusy <= 1'b0;
    cfgValid <= 1'b0;
    hold(3);
    led(1'b1, 1'b0);
    span(2'b10, 500 * MS, 0);
    span(2'b00, 500 * MS, 0);
    cfgValid <= 1'b1;
    ascStop <= 1'b1;
    hold(3);
    led(1'b1, 1'b0);
    span(2'b10, 100 * MS, 1);
    span(2'b00, 100 * MS, 0);
    ascStop <= 1'b0;
    ascTraffic <= 1'b1;
    ascReady <= 1'b1;
    hold(3);
    led(1'b0, 1'b1);
    span(2'b01, 100 * MS, 0);
    span(2'b00, 100 * MS, 0);
    ascTraffic <= 1'b0;
    hold(3);
    led(1'b0, 1'b1);
    hold(200 * MS);
    led(1'b0, 1'b1);
    // Script mode startup
    scrMode = 1'b1;
    wr(`SGSL_CTRL_OFS, 8'h02);
    scrNoScript <= 1'b1;
    hold(3);
    led(1'b1, 1'b0);
    span(2'b10, 200 * MS, 0);
    span(2'b00, 1000 * MS, 0);
    scrNoScript <= 1'b0;
    scrSearch <= 1'b1;
    @(posedge clock);
    scrSearch <= 1'b0;
    hold(3);
    led(1'b1, 1'b0);
    rd(`SGSL_STATE_OFS, 8'h02);
    scrLoadOk <= 1'b1;
    @(posedge clock);
    scrLoadOk <= 1'b0;
    hold(3);
    led(1'b0, 1'b1);
    span(2'b01, 500 * MS, 0);
    led(1'b0, 1'b0);
    rd(`SGSL_STATE_OFS, 8'h08);
    scrStart <= 1'b1;
    @(posedge clock);
    scrStart <= 1'b0;
    hold(3);
    rd(`SGSL_STATE_OFS, 8'h10);
    // Script owns both colours; unused bits read back as zero
    for (int v = 0; v < 4; v++) begin
      seed = xs(seed);
      wr(`SGSL_SCRLED_OFS, {seed[7:2], v[1:0]});
      rd(`SGSL_SCRLED_OFS, {6'h00, v[1:0]});
      led(v[1], v[0]);
    end
    scrHalted <= 1'b1;
    hold(3);
    led(1'b1, 1'b1);
    span(2'b01, 1000 * MS, 0);
    led(1'b1, 1'b1);
    // Script error keeps the flash; dropping the red request must not darken red
    wr(`SGSL_SCRLED_OFS, 8'h01);
    scrHalted <= 1'b0;
    scrError <= 1'b1;
    hold(3);
    led(1'b1, 1'b1);
    // LED off mode is dark; the error flag outlives mode changes
    wr(`SGSL_CTRL_OFS, 8'h03);
    hold(2);
    led(1'b0, 1'b0);
    rd(`SGSL_STATUS_OFS, 8'h0c);
    give_verdict();
  end
endmodule : tb_serial_gateway_status_led
